// >>> hw/cphy_ctrl.sv
// Purpose: Digital control shell of an integrated high-speed CAN transceiver
// Assumes: Analog inputs synchronous to aclk; base_addr static during operation
// Notes:   Mode, dominant timeout, port data, interrupts and AXI4-Lite slave
// Notes on behaviour
// - Transmit input high recessive, low dominant.
// - Receive output high recessive, low dominant.
// - Standby takes wake receiver, shutdown parks recessive, else precision receiver.
// - Port bit 7 reads synchronized wake level.
// - Port bit 1 drives transmit input when routed.
// - Port bit 0 reads synchronized receive level.
// - Shutdown disables everything including wake receiver.
// - Normal enables drivers and receiver; split and wake follow their enables.
// - Pseudo-normal disables low-side driver.
// - Listen-only keeps transmitter off the bus.
// - Standby transceiver off; wake enable resets set.
// - Nine registers decoded from external base address.
// - Set-once enable leaves shutdown for the selected mode, normal after reset.
// - Dominant timeout holds until recessive over 1us.
`timescale 1ns/10ps
module cphy_ctrl
    import cphy_pkg::*;
#(
    parameter int unsigned DT_TIMEOUT_US = DT_TIMEOUT_US_DEF
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [31:0]   base_addr,
    input  wire logic          test_mode,
    input  wire cphy_axi_req_s axi_req,
    output cphy_axi_rsp_s      axi_rsp,
    input  wire logic          controller_tx,
    output logic               phy_rx_out,
    input  wire cphy_ana_in_s  ana_in,
    output cphy_ana_out_s      ana_out,
    output logic               irq
);

    localparam int unsigned DT_CYC_INT = DT_TIMEOUT_US * CLK_MHZ;
    localparam logic [23:0] DT_CYCLES  = DT_CYC_INT[23:0];

    cphy_state_s st_q;
    cphy_state_s st_d;
    logic        phy_tx_in;
    logic        tx_active;
    logic [7:0]  irq_gate;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Decode: offset from base, word aligned, index within map
    function automatic logic [4:0] decode(input logic [31:0] a, input logic [31:0] b);
        logic [31:0] off;
        logic        ok;
        off = a - b;
        ok  = (off[31:6] == 26'h0) && (off[1:0] == 2'h0) && (off[5:2] <= IDX_LAST);
        return {ok, off[5:2]};
    endfunction : decode

    function automatic logic [7:0] rd_mux(input cphy_state_s s, input logic [3:0] idx,
                                          input logic tm);
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            IDX_PORT: begin
                v[PD_WAKE_BIT] = s.s2_wk;
                v[PD_TX_BIT]   = s.tx_drive;
                v[PD_RX_BIT]   = s.s2_rx;
            end
            IDX_CTRL: begin
                v[CR_CPE_BIT]  = s.phy_enable_once;
                v[CR_SPE_BIT]  = s.spe;
                v[CR_WUPE_BIT] = s.wupe;
                v[2:0]         = s.slr;
            end
            IDX_STAT: begin
                v[7:4]       = s.vmon_q;
                v[SR_DT_BIT] = s.dt;
            end
            IDX_RSVA: v = tm ? s.rsv[0] : 8'h00;
            IDX_RSVB: v = tm ? s.rsv[1] : 8'h00;
            IDX_RSVC: v = tm ? s.rsv[2] : 8'h00;
            IDX_IEN:  v = s.ien;
            IDX_IFLG: v = s.iflag;
            IDX_MODE: v = {5'h00, s.route_port, s.msel};
            default:  v = 8'h00;
        endcase
        return v;
    endfunction : rd_mux

    // Port routing replaces the controller bit; both use 1 for recessive
    assign phy_tx_in = st_q.route_port ? st_q.tx_drive : controller_tx;
    assign tx_active = (st_q.mode == PM_NORMAL) || (st_q.mode == PM_PSEUDO);

    always_comb begin
        logic [4:0] dec;
        logic [7:0] rv;
        logic [7:0] w1c;
        logic [7:0] setv;
        logic       wr_fire;
        dec     = 5'h00;
        rv      = 8'h00;
        w1c     = 8'h00;
        setv    = 8'h00;
        wr_fire = 1'b0;
        st_d    = st_q;

        // Mode follows the set-once enable and the selection field
        if (!st_q.phy_enable_once) begin
            st_d.mode = PM_SHUT;
        end else begin
            unique case (st_q.msel)
                MSEL_NORMAL: st_d.mode = PM_NORMAL;
                MSEL_PSEUDO: st_d.mode = PM_PSEUDO;
                MSEL_LISTEN: st_d.mode = PM_LISTEN;
                MSEL_STBY:   st_d.mode = PM_STBY;
            endcase
        end

        // Receive path; shutdown parks it recessive
        unique case (st_q.mode)
            PM_STBY: st_d.rx_out = ana_in.wake_rx;
            PM_SHUT: st_d.rx_out = 1'b1;
            default: st_d.rx_out = ana_in.precise_rx;
        endcase
        st_d.bus_dom = tx_active & ~phy_tx_in;

        // Port data levels are read through two stages, a few cycles behind the pins
        st_d.s1_rx = st_q.rx_out;
        st_d.s2_rx = st_q.s1_rx;
        st_d.s1_wk = ana_in.wake_rx;
        st_d.s2_wk = st_q.s1_wk;

        // Dominant timeout monitor on the transmit input
        if (!phy_tx_in) begin
            st_d.rcnt = 8'h00;
            if (st_q.dcnt < DT_CYCLES) begin
                st_d.dcnt = st_q.dcnt + 24'h000001;
            end else begin
                st_d.dt = 1'b1;
            end
        end else begin
            st_d.dcnt = 24'h000000;
            if (st_q.dt) begin
                if (st_q.rcnt > REC_CYCLES) begin
                    st_d.dt   = 1'b0;
                    st_d.rcnt = 8'h00;
                end else begin
                    st_d.rcnt = st_q.rcnt + 8'h01;
                end
            end
        end

        // Interrupt events: rising edges of monitors and timeout
        st_d.vmon_q = ana_in.volt_fail;
        st_d.oc_q   = ana_in.over_current;
        setv[7:4]   = ana_in.volt_fail & ~st_q.vmon_q;
        setv[3]     = st_d.dt & ~st_q.dt;
        setv[1:0]   = ana_in.over_current & ~st_q.oc_q;

        // AXI4-Lite write channel
        if (axi_req.awvalid && axi_rsp.awready) begin
            dec          = decode(axi_req.awaddr, base_addr);
            st_d.aw_got  = 1'b1;
            st_d.aw_ok   = dec[4];
            st_d.aw_idx  = dec[3:0];
        end
        if (axi_req.wvalid && axi_rsp.wready) begin
            st_d.w_got = 1'b1;
            st_d.wbyte = axi_req.wdata[7:0];
            st_d.wlane = axi_req.wstrb[0];
        end
        if (st_q.bvalid && axi_req.bready) begin
            st_d.bvalid = 1'b0;
        end
        // Both halves held: answer once; unmapped offsets or lane 0 off have no effect
        if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
            wr_fire     = st_q.aw_ok && st_q.wlane;
            st_d.aw_got = 1'b0;
            st_d.w_got  = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp  = st_q.aw_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (wr_fire) begin
            unique case (st_q.aw_idx)
                IDX_PORT: st_d.tx_drive = st_q.wbyte[PD_TX_BIT];
                IDX_CTRL: begin
                    st_d.phy_enable_once  = st_q.phy_enable_once | st_q.wbyte[CR_CPE_BIT];
                    st_d.spe  = st_q.wbyte[CR_SPE_BIT];
                    st_d.wupe = st_q.wbyte[CR_WUPE_BIT];
                    st_d.slr  = st_q.wbyte[2:0];
                end
                IDX_RSVA: if (test_mode) st_d.rsv[0] = st_q.wbyte;
                IDX_RSVB: if (test_mode) st_d.rsv[1] = st_q.wbyte;
                IDX_RSVC: if (test_mode) st_d.rsv[2] = st_q.wbyte;
                IDX_IEN:  st_d.ien = st_q.wbyte & IE_WMASK;
                IDX_IFLG: w1c = st_q.wbyte & IF_WMASK;
                IDX_MODE: begin
                    st_d.msel       = st_q.wbyte[1:0];
                    st_d.route_port = st_q.wbyte[MD_ROUTE_BIT];
                end
                default: ;
            endcase
        end
        // A new event beats a clear in the same cycle
        st_d.iflag = (st_q.iflag & ~w1c) | setv;

        // AXI4-Lite read channel
        if (st_q.rvalid && axi_req.rready) begin
            st_d.rvalid = 1'b0;
        end
        if (axi_req.arvalid && axi_rsp.arready) begin
            dec         = decode(axi_req.araddr, base_addr);
            rv          = rd_mux(st_q, dec[3:0], test_mode);
            st_d.rvalid = 1'b1;
            st_d.rbyte  = dec[4] ? rv : 8'h00;
            st_d.rresp  = dec[4] ? RESP_OKAY : RESP_SLVERR;
        end

        if (!aresetn) begin
            st_d          = '0;
            st_d.mode     = PM_SHUT;
            st_d.tx_drive = PD_RESET[PD_TX_BIT];
            st_d.phy_enable_once      = CR_RESET[CR_CPE_BIT];
            st_d.spe      = CR_RESET[CR_SPE_BIT];
            st_d.wupe     = CR_RESET[CR_WUPE_BIT];
            st_d.msel     = MSEL_NORMAL;
            st_d.rx_out   = 1'b1;
            st_d.s1_rx    = 1'b1;
            st_d.s2_rx    = 1'b1;
            // Wake stages start recessive too, else bit 7 reads dominant after reset
            st_d.s1_wk    = 1'b1;
            st_d.s2_wk    = 1'b1;
        end
    end

    // One register stage holds all state; reset is folded into the next-state logic
    always_ff @(posedge aclk) begin
        st_q <= st_d;
    end

    // Handshake readies are combinational; one write and one read in flight
    assign axi_rsp.awready = !st_q.aw_got && !st_q.bvalid;
    assign axi_rsp.wready  = !st_q.w_got && !st_q.bvalid;
    assign axi_rsp.bvalid  = st_q.bvalid;
    assign axi_rsp.bresp   = st_q.bresp;
    assign axi_rsp.arready = !st_q.rvalid;
    assign axi_rsp.rvalid  = st_q.rvalid;
    assign axi_rsp.rdata   = {24'h000000, st_q.rbyte};
    assign axi_rsp.rresp   = st_q.rresp;

    assign phy_rx_out = st_q.rx_out;

    // Analog enables decoded from the registered mode
    assign ana_out.drv_high_en  = tx_active;
    assign ana_out.drv_low_en   = (st_q.mode == PM_NORMAL);
    assign ana_out.bus_dominant = st_q.bus_dom;
    assign ana_out.rx_en        = (st_q.mode == PM_NORMAL) || (st_q.mode == PM_PSEUDO)
                                  || (st_q.mode == PM_LISTEN);
    assign ana_out.wake_en      = (st_q.mode != PM_SHUT) && st_q.wupe;
    assign ana_out.split_en     = ((st_q.mode == PM_NORMAL) || (st_q.mode == PM_LISTEN))
                                  && st_q.spe;
    assign ana_out.slew_rate    = st_q.slr;

    // One over-current enable gates both over-current flags
    assign irq_gate = {{4{st_q.ien[IE_VF_BIT]}}, st_q.ien[IE_DT_BIT], 1'b0,
                       {2{st_q.ien[IE_OC_BIT]}}};
    assign irq      = |(st_q.iflag & irq_gate);

    a_rx_standby: assert property ((st_q.mode == PM_STBY) |=>
        (phy_rx_out == $past(ana_in.wake_rx)))
        else $error("receive output not from wake receiver in standby");

    a_shut_all_off: assert property ((st_q.mode == PM_SHUT) |->
        (!ana_out.wake_en && !ana_out.drv_high_en && !ana_out.rx_en && !ana_out.bus_dominant))
        else $error("shutdown left a function enabled");

    a_enable_sticky: assert property (st_q.phy_enable_once |=> st_q.phy_enable_once)
        else $error("set-once enable was cleared");

    a_enable_normal: assert property (($rose(st_q.phy_enable_once) && st_q.msel == MSEL_NORMAL)
        |-> (st_q.mode == PM_SHUT) ##1 (st_q.mode == PM_NORMAL))
        else $error("enable did not enter normal mode");

    a_listen_quiet: assert property ((st_q.mode == PM_LISTEN) |=>
        (!ana_out.drv_high_en && !ana_out.drv_low_en && !ana_out.bus_dominant) or
        (st_q.mode != PM_LISTEN))
        else $error("listen-only reached the bus");

    a_pseudo_low_off: assert property ((st_q.mode == PM_PSEUDO) |->
        (ana_out.drv_high_en && !ana_out.drv_low_en))
        else $error("pseudo-normal driver enables wrong");

    a_normal_split: assert property ((st_q.mode == PM_NORMAL) |->
        (ana_out.split_en == st_q.spe && ana_out.drv_low_en && ana_out.rx_en))
        else $error("normal mode enables wrong");

    a_timeout_hold: assert property ((st_q.dt && !phy_tx_in) |=> st_q.dt)
        else $error("timeout dropped while still dominant");

    // Synchronizer checks count the stages from the last edge that saw reset
    a_sync_depth: assert property (($past(aresetn) && $past(aresetn, 2)) |->
        (st_q.s2_rx == $past(st_q.rx_out, 2)))
        else $error("receive level synchronizer depth wrong");

    a_wake_default: assert property (!$past(aresetn) |-> st_q.wupe)
        else $error("wake enable not set after reset");

    a_wake_sync: assert property (($past(aresetn) && $past(aresetn, 2)) |->
        (st_q.s2_wk == $past(ana_in.wake_rx, 2)))
        else $error("wake level synchronizer depth wrong");

    // The driver mirrors the transmit input one cycle late while it may transmit
    a_tx_to_bus: assert property (tx_active |=>
        (ana_out.bus_dominant == !$past(phy_tx_in)))
        else $error("transmit level not mapped to bus");

    a_tx_idle_bus: assert property (!tx_active |=> !ana_out.bus_dominant)
        else $error("bus driven while transmitter is off");

    a_port_drive: assert property ((st_q.route_port && tx_active) |=>
        (ana_out.bus_dominant == !$past(st_q.tx_drive)))
        else $error("port data bit did not drive the transmit input");

    // Receive path source per mode
    a_rx_precise: assert property (
        (st_q.mode inside {PM_NORMAL, PM_PSEUDO, PM_LISTEN}) |=>
        (phy_rx_out == $past(ana_in.precise_rx)))
        else $error("receive output not from precision receiver");

    a_shut_rx_idle: assert property ((st_q.mode == PM_SHUT) |=> phy_rx_out)
        else $error("receive output not recessive in shutdown");

    // Analog enables per mode
    a_split_off: assert property (
        (st_q.mode inside {PM_SHUT, PM_PSEUDO, PM_STBY}) |-> !ana_out.split_en)
        else $error("split driven outside normal and listen-only");

    a_pseudo_rx: assert property ((st_q.mode == PM_PSEUDO) |-> ana_out.rx_en)
        else $error("pseudo-normal receiver disabled");

    a_standby_off: assert property ((st_q.mode == PM_STBY) |->
        (!ana_out.drv_high_en && !ana_out.drv_low_en && !ana_out.rx_en))
        else $error("standby left the transceiver enabled");

    a_standby_wake: assert property ((st_q.mode == PM_STBY && st_q.wupe) |->
        ana_out.wake_en)
        else $error("standby wake receiver not enabled");

    a_enable_leaves: assert property (st_q.phy_enable_once |=> (st_q.mode != PM_SHUT))
        else $error("enabled block stayed in shutdown");

    // Register decode and reserved space
    a_addr_unmapped: assert property (
        (st_q.aw_got && st_q.w_got && !st_q.bvalid && !st_q.aw_ok) |=>
        (axi_rsp.bvalid && axi_rsp.bresp == RESP_SLVERR))
        else $error("unmapped write not refused");

    a_reserved_quiet: assert property (!test_mode |=> $stable(st_q.rsv))
        else $error("reserved register changed outside test mode");

    // Timeout sets at the end of the count and holds through a short recessive spell
    a_dt_set: assert property ((!phy_tx_in && st_q.dcnt == DT_CYCLES) |=> st_q.dt)
        else $error("dominant timeout did not set");

    a_dt_release: assert property ((st_q.dt && st_q.rcnt <= REC_CYCLES) |=> st_q.dt)
        else $error("timeout cleared before recessive hold time");

endmodule : cphy_ctrl

// >>> hw/cphy_pkg.sv
// Purpose: Shared constants, modes and carriers of the CAN transceiver control shell
// Assumes: 125 MHz bus clock, AXI4-Lite register access
// Notes:   Register index n sits at byte offset 4*n from the module base address
package cphy_pkg;

    localparam int unsigned CLK_MHZ     = 125;
    localparam int unsigned REC_HOLD_NS = 1000;
    localparam int unsigned REC_CYC_INT = (REC_HOLD_NS * CLK_MHZ) / 1000;
    localparam logic [7:0]  REC_CYCLES  = REC_CYC_INT[7:0];
    localparam int unsigned DT_TIMEOUT_US_DEF = 1000;

    localparam logic [3:0] IDX_PORT  = 4'h0;
    localparam logic [3:0] IDX_CTRL  = 4'h1;
    localparam logic [3:0] IDX_RSVA  = 4'h2;
    localparam logic [3:0] IDX_STAT  = 4'h3;
    localparam logic [3:0] IDX_RSVB  = 4'h4;
    localparam logic [3:0] IDX_RSVC  = 4'h5;
    localparam logic [3:0] IDX_IEN   = 4'h6;
    localparam logic [3:0] IDX_IFLG  = 4'h7;
    localparam logic [3:0] IDX_MODE  = 4'h8;
    localparam logic [3:0] IDX_LAST  = 4'h8;

    localparam int unsigned PD_WAKE_BIT = 7;
    localparam int unsigned PD_TX_BIT   = 1;
    localparam int unsigned PD_RX_BIT   = 0;
    localparam int unsigned CR_CPE_BIT  = 7;
    localparam int unsigned CR_SPE_BIT  = 6;
    localparam int unsigned CR_WUPE_BIT = 5;
    localparam int unsigned SR_DT_BIT   = 3;
    localparam int unsigned IE_VF_BIT   = 4;
    localparam int unsigned IE_DT_BIT   = 3;
    localparam int unsigned IE_OC_BIT   = 0;
    localparam int unsigned MD_ROUTE_BIT = 2;

    localparam logic [7:0] PD_RESET   = 8'h02;
    localparam logic [7:0] CR_RESET   = 8'h20;
    localparam logic [7:0] IE_WMASK   = 8'h19;
    localparam logic [7:0] IF_WMASK   = 8'hfb;

    localparam logic [1:0] MSEL_NORMAL = 2'h0;
    localparam logic [1:0] MSEL_PSEUDO = 2'h1;
    localparam logic [1:0] MSEL_LISTEN = 2'h2;
    localparam logic [1:0] MSEL_STBY   = 2'h3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        PM_SHUT   = 5'h01,
        PM_NORMAL = 5'h02,
        PM_PSEUDO = 5'h04,
        PM_LISTEN = 5'h08,
        PM_STBY   = 5'h10
    } cphy_mode_e;

    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } cphy_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } cphy_axi_rsp_s;

    typedef struct packed {
        logic       precise_rx;
        logic       wake_rx;
        logic [3:0] volt_fail;
        logic [1:0] over_current;
    } cphy_ana_in_s;

    typedef struct packed {
        logic       drv_high_en;
        logic       drv_low_en;
        logic       bus_dominant;
        logic       rx_en;
        logic       wake_en;
        logic       split_en;
        logic [2:0] slew_rate;
    } cphy_ana_out_s;

    typedef struct packed {
        cphy_mode_e      mode;
        logic            tx_drive;
        logic            phy_enable_once;
        logic            spe;
        logic            wupe;
        logic [2:0]      slr;
        logic [1:0]      msel;
        logic            route_port;
        logic [2:0][7:0] rsv;
        logic [7:0]      ien;
        logic [7:0]      iflag;
        logic            dt;
        logic [23:0]     dcnt;
        logic [7:0]      rcnt;
        logic [3:0]      vmon_q;
        logic [1:0]      oc_q;
        logic            rx_out;
        logic            bus_dom;
        logic            s1_rx;
        logic            s2_rx;
        logic            s1_wk;
        logic            s2_wk;
        logic            aw_got;
        logic            aw_ok;
        logic [3:0]      aw_idx;
        logic            w_got;
        logic [7:0]      wbyte;
        logic            wlane;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            rvalid;
        logic [7:0]      rbyte;
        logic [1:0]      rresp;
    } cphy_state_s;

endpackage : cphy_pkg

// >>> test/cphy_far_model.sv
// Purpose: Far side of the shell: protocol controller bit source and CAN bus loopback
// Assumes: Bus idles recessive whenever the driver is not forcing dominant
// Notes:   Wake receiver level is pulled by the bench to tell it apart in standby
`timescale 1ns/10ps
module cphy_far_model
    import cphy_pkg::*;
(
    input  wire logic          tx_level,
    input  wire logic          wake_level,
    input  wire cphy_ana_out_s ana_out,
    output logic               controller_tx,
    output cphy_ana_in_s       ana_in
);
    // Controller sends 1 for recessive, 0 for dominant
    assign controller_tx          = tx_level;
    // Both receivers see the bus the shell itself drives; wake path can be pulled low alone
    assign ana_in.precise_rx      = !ana_out.bus_dominant;
    assign ana_in.wake_rx         = wake_level & !ana_out.bus_dominant;
    assign ana_in.volt_fail       = 4'h0;
    assign ana_in.over_current    = 2'h0;
endmodule : cphy_far_model

// >>> test/tb_can_phy_digital_control.sv
// Purpose: Self-checking bench of the transceiver control shell over AXI4-Lite
// Assumes: Dominant timeout shortened to 1 us (125 cycles) for run length
// Notes:   Each scenario task drives the block and judges the result itself
`timescale 1ns/10ps
module tb_can_phy_digital_control;
    import cphy_pkg::*;
    localparam logic [31:0] BASE = 32'h4000_0100;
    logic          aclk;
    logic          aresetn;
    logic          tx_level;
    logic          wake_level;
    logic          test_mode;
    logic          controller_tx;
    logic          phy_rx_out;
    logic          irq;
    cphy_axi_req_s req;
    cphy_axi_rsp_s rsp;
    cphy_ana_in_s  ana_in;
    cphy_ana_out_s ana_out;
    int            errors;
    int            comparisons;
    logic [31:0]   d;
    logic [1:0]    r;

    always #4 aclk = ~aclk;

    cphy_ctrl #(.DT_TIMEOUT_US(1)) dut (
        .aclk(aclk), .aresetn(aresetn), .base_addr(BASE), .test_mode(test_mode),
        .axi_req(req), .axi_rsp(rsp), .controller_tx(controller_tx),
        .phy_rx_out(phy_rx_out), .ana_in(ana_in), .ana_out(ana_out), .irq(irq)
    );
    cphy_far_model far (
        .tx_level(tx_level), .wake_level(wake_level), .ana_out(ana_out),
        .controller_tx(controller_tx), .ana_in(ana_in)
    );

    task automatic report_and_stop;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Holds each channel until its own handshake edge; bench timeout bounds the wait
    task automatic wr(input logic [3:0] idx, input logic [7:0] v, output logic [1:0] resp);
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr  <= BASE + {26'h0, idx, 2'b00};
        req.wvalid  <= 1'b1;
        req.wdata   <= {24'h0, v};
        req.wstrb   <= 4'hf;
        req.bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (req.awvalid && rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready === 1'b1) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        resp = rsp.bresp;
        req.bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] idx, output logic [31:0] v, output logic [1:0] resp);
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr  <= BASE + {26'h0, idx, 2'b00};
        req.rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (req.arvalid && rsp.arready === 1'b1) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        v = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
    endtask : rd

    task automatic t_reset;
        rd(IDX_PORT, d, r);
        chk(d, 32'h83);
        rd(IDX_CTRL, d, r);
        chk(d, 32'h20);
        chk(ana_out.wake_en, 1'b0);
        chk(ana_out.rx_en, 1'b0);
        rd(4'h9, d, r);
        chk(r, RESP_SLVERR);
        chk(d, 32'h0);
        wr(4'h9, 8'hff, r);
        chk(r, RESP_SLVERR);
        $display("done reset values");
    endtask : t_reset

    task automatic t_enable;
        wr(IDX_CTRL, 8'ha0, r);
        chk(r, RESP_OKAY);
        wr(IDX_CTRL, 8'h20, r);
        rd(IDX_CTRL, d, r);
        chk(d, 32'ha0);
        chk(ana_out.drv_low_en, 1'b1);
        chk(ana_out.split_en, 1'b0);
        wr(IDX_CTRL, 8'he5, r);
        repeat (2) @(posedge aclk);
        chk(ana_out.split_en, 1'b1);
        chk(ana_out.slew_rate, 32'h5);
        $display("done enable");
    endtask : t_enable

    task automatic t_tx_path;
        @(posedge aclk);
        tx_level <= 1'b0;
        repeat (6) @(posedge aclk);
        chk(ana_out.bus_dominant, 1'b1);
        chk(phy_rx_out, 1'b0);
        rd(IDX_PORT, d, r);
        chk(d, 32'h02);
        tx_level <= 1'b1;
        repeat (6) @(posedge aclk);
        chk(ana_out.bus_dominant, 1'b0);
        chk(phy_rx_out, 1'b1);
        $display("done transmit path");
    endtask : t_tx_path

    task automatic t_modes;
        wr(IDX_MODE, {6'h0, MSEL_PSEUDO}, r);
        repeat (2) @(posedge aclk);
        chk(ana_out.drv_low_en, 1'b0);
        chk(ana_out.drv_high_en, 1'b1);
        wr(IDX_MODE, {6'h0, MSEL_LISTEN}, r);
        tx_level <= 1'b0;
        repeat (6) @(posedge aclk);
        chk(ana_out.bus_dominant, 1'b0);
        chk(ana_out.rx_en, 1'b1);
        tx_level <= 1'b1;
        wr(IDX_MODE, {6'h0, MSEL_STBY}, r);
        wake_level <= 1'b0;
        repeat (6) @(posedge aclk);
        chk(phy_rx_out, 1'b0);
        chk(ana_out.drv_high_en, 1'b0);
        chk(ana_out.wake_en, 1'b1);
        rd(IDX_PORT, d, r);
        chk(d, 32'h02);
        wake_level <= 1'b1;
        wr(IDX_MODE, {6'h0, MSEL_NORMAL}, r);
        repeat (4) @(posedge aclk);
        chk(phy_rx_out, 1'b1);
        $display("done modes");
    endtask : t_modes

    task automatic t_route;
        wr(IDX_MODE, 8'h04, r);
        wr(IDX_PORT, 8'h00, r);
        repeat (3) @(posedge aclk);
        chk(ana_out.bus_dominant, 1'b1);
        wr(IDX_PORT, 8'h02, r);
        repeat (3) @(posedge aclk);
        chk(ana_out.bus_dominant, 1'b0);
        wr(IDX_MODE, 8'h00, r);
        $display("done port routing");
    endtask : t_route

    task automatic t_timeout;
        wr(IDX_IEN, 8'h00, r);
        tx_level <= 1'b0;
        repeat (140) @(posedge aclk);
        rd(IDX_STAT, d, r);
        chk(d, 32'h08);
        chk(irq, 1'b0);
        wr(IDX_IEN, 8'h08, r);
        chk(irq, 1'b1);
        tx_level <= 1'b1;
        repeat (60) @(posedge aclk);
        rd(IDX_STAT, d, r);
        chk(d, 32'h08);
        repeat (100) @(posedge aclk);
        rd(IDX_STAT, d, r);
        chk(d, 32'h00);
        wr(IDX_IFLG, 8'h08, r);
        chk(irq, 1'b0);
        $display("done dominant timeout");
    endtask : t_timeout

    task automatic t_reserved;
        logic [3:0] rs [4];
        rs = '{IDX_RSVA, IDX_RSVB, IDX_RSVC, IDX_STAT};
        foreach (rs[i]) begin
            wr(rs[i], 8'hff, r);
            rd(rs[i], d, r);
            chk(d, 32'h0);
        end
        test_mode <= 1'b1;
        wr(IDX_RSVB, 8'h5a, r);
        rd(IDX_RSVB, d, r);
        chk(d, 32'h5a);
        test_mode <= 1'b0;
        rd(IDX_RSVB, d, r);
        chk(d, 32'h0);
        $display("done reserved registers");
    endtask : t_reserved

    initial begin
        aclk       = 1'b0;
        aresetn    = 1'b0;
        req        = '0;
        tx_level   = 1'b1;
        wake_level = 1'b1;
        test_mode  = 1'b0;
        errors     = 0;
        comparisons = 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_enable();
        t_tx_path();
        t_modes();
        t_route();
        t_timeout();
        t_reserved();
        report_and_stop();
    end

    // Whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        report_and_stop();
    end
endmodule : tb_can_phy_digital_control
